// File: aux_timer_baud_generator.sv
// auxiliary 16-bit timer with baud generator mode and four-mode serial port
// assumes clk_i is the oscillator, all pins synchronous, classic wishbone master
//
// The address map and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
module aux_timer_baud_generator
	import aux_timer_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [4:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        aux_clock_pin_i,
	input  wire logic        aux_trigger_pin_i,
	input  wire logic        other_timer_ovf_i,
	input  wire logic        rxd_i,
	output logic             rxd_o,
	output logic             rxd_oe_o,
	output logic             txd_o
);

	function automatic logic hit(input logic [4:0] adr, input logic [4:0] off);
		hit = (adr[4:2] == off[4:2]);
	endfunction

	// ----------------------------------------------------------------
	// wishbone slave
	// ----------------------------------------------------------------
	logic        ack_reg;
	logic [31:0] dat_reg;
	logic [7:0]  ctrl_reg, sctrl_reg, rbuf_reg, rld_lo_reg, rld_hi_reg;
	logic [15:0] cnt_reg;
	logic        smod_reg;

	wire       bus_req  = wb_cyc_i && wb_stb_i;
	wire       bus_wr   = bus_req && wb_we_i && ack_reg && wb_sel_i[0];
	wire [7:0] wbyte    = wb_dat_i[7:0];
	wire       wr_ctrl  = bus_wr && hit(wb_adr_i, OFF_CTRL);
	wire       wr_cntlo = bus_wr && hit(wb_adr_i, OFF_CNT_LO);
	wire       wr_cnthi = bus_wr && hit(wb_adr_i, OFF_CNT_HI);
	wire       wr_rldlo = bus_wr && hit(wb_adr_i, OFF_RLD_LO);
	wire       wr_rldhi = bus_wr && hit(wb_adr_i, OFF_RLD_HI);
	wire       wr_sctrl = bus_wr && hit(wb_adr_i, OFF_SCTRL);
	wire       wr_serial_buffer  = bus_wr && hit(wb_adr_i, OFF_SERIAL_BUFFER);
	wire       wr_cfg   = bus_wr && hit(wb_adr_i, OFF_CFG);

	wire [7:0] rd_byte =
		hit(wb_adr_i, OFF_CTRL)   ? ctrl_reg :
		hit(wb_adr_i, OFF_CNT_LO) ? cnt_reg[7:0] :
		hit(wb_adr_i, OFF_CNT_HI) ? cnt_reg[15:8] :
		hit(wb_adr_i, OFF_RLD_LO) ? rld_lo_reg :
		hit(wb_adr_i, OFF_RLD_HI) ? rld_hi_reg :
		hit(wb_adr_i, OFF_SCTRL)  ? sctrl_reg :
		hit(wb_adr_i, OFF_SERIAL_BUFFER)   ? rbuf_reg :
		{7'h00, smod_reg};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= bus_req && !ack_reg;
			if (bus_req && !ack_reg)
				dat_reg <= {24'h00_0000, rd_byte};
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	// ----------------------------------------------------------------
	// state time, machine cycle and mode 2 prescalers
	// ----------------------------------------------------------------
	logic       st_reg, t1_half_reg, pin_prev_reg, trig_prev_reg;
	logic [3:0] mc_reg;
	logic [1:0] pre_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg        <= 1'b0;
			mc_reg        <= MACH_FIRST;
			pre_reg       <= 2'h0;
			t1_half_reg   <= 1'b0;
			pin_prev_reg  <= 1'b1;
			trig_prev_reg <= 1'b1;
		end else begin
			st_reg        <= !st_reg;
			mc_reg        <= (mc_reg == MACH_LAST) ? MACH_FIRST : 4'(mc_reg + 4'h1);
			pre_reg       <= 2'(pre_reg + 2'h1);
			t1_half_reg   <= t1_half_reg ^ other_timer_ovf_i;
			pin_prev_reg  <= aux_clock_pin_i;
			trig_prev_reg <= aux_trigger_pin_i;
		end
	end

	wire state_tick = st_reg;
	wire mach_tick  = (mc_reg == MACH_LAST);
	wire clk_fall   = pin_prev_reg && !aux_clock_pin_i;
	wire trig_fall  = trig_prev_reg && !aux_trigger_pin_i;

	// ----------------------------------------------------------------
	// auxiliary timer
	// ----------------------------------------------------------------
	wire        baud_mode = ctrl_reg[TC_RCLK] || ctrl_reg[TC_TX_CLOCK_SELECT];
	wire        int_tick  = baud_mode ? state_tick : mach_tick;
	wire        t2_tick   = ctrl_reg[TC_RUN] &&
	                        (ctrl_reg[TC_CSEL] ? clk_fall : int_tick);
	wire        t2_ovf    = t2_tick && (cnt_reg == CNT_MAX);
	wire        ext_evt   = ctrl_reg[TC_EXEN] && trig_fall;
	wire        t2_reload = baud_mode ? t2_ovf :
	                        (!ctrl_reg[TC_CAPRL] && (t2_ovf || ext_evt));
	wire        capture   = !baud_mode && ctrl_reg[TC_CAPRL] && ext_evt;
	wire        ovf_set   = t2_ovf && !baud_mode;
	wire [15:0] cnt_next  = t2_reload ? {rld_hi_reg, rld_lo_reg} :
	                        t2_tick ? 16'(cnt_reg + 16'h0001) : cnt_reg;

	logic [7:0] ctrl_next;
	always_comb begin
		ctrl_next = wr_ctrl ? wbyte : ctrl_reg;
		if (ovf_set)
			ctrl_next[TC_OVF] = 1'b1;
		if (ext_evt)
			ctrl_next[TC_EXT] = 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg   <= BYTE_RST;
			cnt_reg    <= CNT_RST;
			rld_lo_reg <= BYTE_RST;
			rld_hi_reg <= BYTE_RST;
			smod_reg   <= 1'b0;
		end else begin
			ctrl_reg   <= ctrl_next;
			cnt_reg    <= {wr_cnthi ? wbyte : cnt_next[15:8],
			               wr_cntlo ? wbyte : cnt_next[7:0]};
			rld_lo_reg <= capture ? cnt_reg[7:0] : (wr_rldlo ? wbyte : rld_lo_reg);
			rld_hi_reg <= capture ? cnt_reg[15:8] : (wr_rldhi ? wbyte : rld_hi_reg);
			smod_reg   <= wr_cfg ? wbyte[CFG_SMOD] : smod_reg;
		end
	end

	// ----------------------------------------------------------------
	// serial bit-rate ticks (sixteen per bit)
	// ----------------------------------------------------------------
	serial_mode_e mode;
	assign mode = serial_mode_e'(sctrl_reg[7:6]);

	wire t1_tick16 = other_timer_ovf_i && (smod_reg || t1_half_reg);
	wire m2_tick   = smod_reg ? pre_reg[0] : (&pre_reg);
	wire tx_tick   = (mode == MODE_9FIX) ? m2_tick :
	                 (ctrl_reg[TC_TX_CLOCK_SELECT] ? t2_ovf : t1_tick16);
	wire rx_tick   = (mode == MODE_9FIX) ? m2_tick :
	                 (ctrl_reg[TC_RCLK] ? t2_ovf : t1_tick16);

	// ----------------------------------------------------------------
	// transmitter and mode 0 shifter
	// ----------------------------------------------------------------
	logic       tx_busy_reg, m0_busy_reg, m0_tx_reg, txd_reg, rxd_o_reg, rxd_oe_reg;
	logic [3:0] tx_sub_reg, tx_left_reg, m0_cnt_reg;
	logic [9:0] tx_sh_reg;
	logic [7:0] m0_sh_reg;

	wire tx_ninth = (mode == MODE_8BIT) ? 1'b1 : sctrl_reg[SC_TB8];
	wire tx_done  = tx_busy_reg && tx_tick && (tx_sub_reg == OVS_LAST) &&
	                (tx_left_reg == 4'h0);
	wire m0_rise  = m0_busy_reg && (mc_reg == MACH_MID) && !txd_reg;
	wire m0_end   = m0_rise && (m0_cnt_reg == M0_LAST);
	wire m0_rx_go = sctrl_reg[SC_REN] && !sctrl_reg[SC_RI];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_busy_reg <= 1'b0;
			tx_sub_reg  <= 4'h0;
			tx_left_reg <= 4'h0;
			tx_sh_reg   <= 10'h000;
			m0_busy_reg <= 1'b0;
			m0_tx_reg   <= 1'b0;
			m0_cnt_reg  <= 4'h0;
			m0_sh_reg   <= BYTE_RST;
			txd_reg     <= 1'b1;
			rxd_o_reg   <= 1'b1;
			rxd_oe_reg  <= 1'b0;
		end else if (mode == MODE_SHIFT) begin
			tx_busy_reg <= 1'b0;
			if (!m0_busy_reg) begin
				txd_reg    <= 1'b1;
				rxd_oe_reg <= 1'b0;
				if (wr_serial_buffer) begin
					m0_busy_reg <= 1'b1;
					m0_tx_reg   <= 1'b1;
					m0_sh_reg   <= wbyte;
					m0_cnt_reg  <= 4'h0;
				end else if (m0_rx_go) begin
					m0_busy_reg <= 1'b1;
					m0_tx_reg   <= 1'b0;
					m0_cnt_reg  <= 4'h0;
				end
			end else if (mc_reg == MACH_FIRST) begin
				txd_reg    <= 1'b0;
				rxd_oe_reg <= m0_tx_reg;
				rxd_o_reg  <= m0_sh_reg[0];
			end else if (m0_rise) begin
				txd_reg    <= 1'b1;
				m0_sh_reg  <= {rxd_i, m0_sh_reg[7:1]};
				m0_cnt_reg <= 4'(m0_cnt_reg + 4'h1);
				if (m0_end)
					m0_busy_reg <= 1'b0;
			end
		end else begin
			m0_busy_reg <= 1'b0;
			rxd_oe_reg  <= 1'b0;
			if (!tx_busy_reg) begin
				txd_reg <= 1'b1;
				if (wr_serial_buffer) begin
					tx_busy_reg <= 1'b1;
					txd_reg     <= 1'b0;
					tx_sub_reg  <= 4'h0;
					tx_sh_reg   <= {1'b1, tx_ninth, wbyte};
					tx_left_reg <= (mode == MODE_8BIT) ? LEFT_M1 : LEFT_M23;
				end
			end else if (tx_tick) begin
				tx_sub_reg <= 4'(tx_sub_reg + 4'h1);
				if (tx_sub_reg == OVS_LAST) begin
					if (tx_left_reg == 4'h0) begin
						tx_busy_reg <= 1'b0;
						txd_reg     <= 1'b1;
					end else begin
						txd_reg     <= tx_sh_reg[0];
						tx_sh_reg   <= {1'b1, tx_sh_reg[9:1]};
						tx_left_reg <= 4'(tx_left_reg - 4'h1);
					end
				end
			end
		end
	end
	assign txd_o    = txd_reg;
	assign rxd_o    = rxd_o_reg;
	assign rxd_oe_o = rxd_oe_reg;

	// ----------------------------------------------------------------
	// asynchronous receiver
	// ----------------------------------------------------------------
	logic       rx_busy_reg;
	logic [3:0] rx_sub_reg, rx_cnt_reg;
	logic [8:0] rx_sh_reg;

	wire rx_fin  = rx_busy_reg && rx_tick && (rx_sub_reg == OVS_MID) &&
	               (rx_cnt_reg == RX_LAST);
	wire rx_load = rx_fin && !sctrl_reg[SC_RI];
	wire m0_load = m0_end && !m0_tx_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_busy_reg <= 1'b0;
			rx_sub_reg  <= 4'h0;
			rx_cnt_reg  <= 4'h0;
			rx_sh_reg   <= 9'h000;
		end else if (!rx_busy_reg) begin
			if (mode != MODE_SHIFT && sctrl_reg[SC_REN] && !rxd_i) begin
				rx_busy_reg <= 1'b1;
				rx_sub_reg  <= 4'h0;
				rx_cnt_reg  <= 4'h0;
			end
		end else if (mode == MODE_SHIFT) begin
			rx_busy_reg <= 1'b0;
		end else if (rx_tick) begin
			rx_sub_reg <= 4'(rx_sub_reg + 4'h1);
			if (rx_sub_reg == OVS_MID) begin
				if (rx_cnt_reg == 4'h0 && rxd_i) begin
					rx_busy_reg <= 1'b0;
				end else begin
					rx_sh_reg  <= {rxd_i, rx_sh_reg[8:1]};
					rx_cnt_reg <= 4'(rx_cnt_reg + 4'h1);
					if (rx_cnt_reg == RX_LAST)
						rx_busy_reg <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// serial control and receive buffer
	// ----------------------------------------------------------------
	logic [7:0] sctrl_next;
	always_comb begin
		sctrl_next = wr_sctrl ? wbyte : sctrl_reg;
		if (tx_done || (m0_end && m0_tx_reg))
			sctrl_next[SC_TI] = 1'b1;
		if (rx_load || m0_load)
			sctrl_next[SC_RI] = 1'b1;
		if (rx_load)
			sctrl_next[SC_RB8] = rxd_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sctrl_reg <= BYTE_RST;
			rbuf_reg  <= BYTE_RST;
		end else begin
			sctrl_reg <= sctrl_next;
			if (rx_load)
				rbuf_reg <= rx_sh_reg[8:1];
			else if (m0_load)
				rbuf_reg <= {rxd_i, m0_sh_reg[7:1]};
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	baud_no_ovf_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(baud_mode && t2_ovf && !ctrl_reg[TC_OVF] && !wr_ctrl) |=> !ctrl_reg[TC_OVF])
		else $error("baud rollover set overflow flag");
	baud_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(baud_mode && t2_ovf && !wr_cntlo && !wr_cnthi) |=>
		cnt_reg == {$past(rld_hi_reg), $past(rld_lo_reg)})
		else $error("rollover did not reload count");
	trig_no_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(baud_mode && ext_evt && !t2_tick && !wr_cntlo && !wr_cnthi && !wr_ctrl) |=>
		ctrl_reg[TC_EXT] && $stable(cnt_reg))
		else $error("trigger in baud mode reloaded or missed flag");
	state_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state_tick |=> !state_tick ##1 state_tick)
		else $error("state time spacing wrong");
	mach_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
		mach_tick |=> !mach_tick [*8])
		else $error("machine cycle spacing wrong");
	tx_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_serial_buffer && mode != MODE_SHIFT && !tx_busy_reg) |=> tx_busy_reg && !txd_o)
		else $error("buffer write did not start frame");
	tx_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode != MODE_SHIFT && $fell(tx_busy_reg)) |-> sctrl_reg[SC_TI])
		else $error("frame end did not set transmit done");
	tx_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tx_busy_reg && mode == MODE_8BIT && !ctrl_reg[TC_TX_CLOCK_SELECT] && !other_timer_ovf_i)
		|=> $stable(tx_sub_reg) || !tx_busy_reg)
		else $error("transmit advanced without other timer");
	rx_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!rx_busy_reg && !sctrl_reg[SC_REN]) |=> !rx_busy_reg)
		else $error("receiver started while disabled");
	m0_oe_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(rxd_oe_o && !txd_o) |-> mode == MODE_SHIFT && m0_tx_reg)
		else $error("receive pin driven outside mode 0 send");

endmodule

// File: aux_timer_baud_generator_bench.sv
// self-checking bench for the auxiliary timer baud generator
// assumes serial_peer on the line pair and a pulled-up receive pin
`timescale 1ns/1ps
module aux_timer_baud_generator_bench;
	import aux_timer_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [4:0]  wb_adr = 5'h00;
	logic [3:0]  wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0, wb_dat_o;
	logic        wb_ack_o, clk_pin = 1'b1, trig_pin = 1'b1, other_ovf = 1'b0, gen_on = 1'b0;
	logic        rxd_o, rxd_oe_o, txd_o, peer_rxd;
	wire logic   rxd_line;
	int          error_cnt = 0, tests_run = 0;
	logic [31:0] q;
	logic [10:0] fr;

	assign rxd_line = rxd_oe_o ? rxd_o : peer_rxd;
	always #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) other_ovf <= gen_on & ~other_ovf;

	aux_timer_baud_generator aux_timer_baud_generator_inst (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .aux_clock_pin_i(clk_pin),
		.aux_trigger_pin_i(trig_pin), .other_timer_ovf_i(other_ovf), .rxd_i(rxd_line),
		.rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o));
	serial_peer #(.BIT_CLKS(64)) serial_peer_inst (
		.clk_i(clk_i), .line_i(txd_o), .line_o(peer_rxd));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask

	task automatic wb_xfer(input logic we, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} <= {2'b11, we, a, 4'h1, 24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		chk(n < 20, "no bus answer");
		{wb_cyc, wb_stb, wb_we} <= 3'b000;
	endtask

	task automatic baud_setup(input logic [7:0] ctrl, input logic [7:0] rlo);
		wb_xfer(1'b1, OFF_CTRL, 8'h00);
		wb_xfer(1'b1, OFF_RLD_LO, rlo);
		wb_xfer(1'b1, OFF_RLD_HI, 8'hff);
		wb_xfer(1'b1, OFF_CNT_LO, rlo);
		wb_xfer(1'b1, OFF_CNT_HI, 8'hff);
		wb_xfer(1'b1, OFF_CTRL, ctrl);
	endtask

	// sends one byte and compares the whole frame seen on the wire
	task automatic tx_frame(input logic [7:0] sc, input logic [7:0] d, input logic [10:0] exp,
		input int n);
		wb_xfer(1'b1, OFF_SCTRL, sc);
		fork
			serial_peer_inst.recv_bits(fr, n);
			wb_xfer(1'b1, OFF_SERIAL_BUFFER, d);
		join
		chk(fr === exp, "sent frame wrong");
		wb_xfer(1'b0, OFF_SCTRL, 8'h00);
		chk(q[SC_TI] === 1'b1, "tx done not set");
		wb_xfer(1'b1, OFF_SCTRL, 8'h00);
	endtask

	task automatic pulse_trig();
		@(posedge clk_i) trig_pin <= 1'b0;
		repeat (4) @(posedge clk_i);
		trig_pin <= 1'b1;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic reset_values();
		wb_xfer(1'b0, OFF_CTRL, 8'h00);
		chk(q === 32'h0, "control reset");
		wb_xfer(1'b0, OFF_SCTRL, 8'h00);
		chk(q === 32'h0, "serial control reset");
		chk(txd_o === 1'b1 && rxd_oe_o === 1'b0, "pin idle");
	endtask

	// reload fffe gives osc/64 bits: 64 clocks each
	task automatic m1_tx_aux();
		baud_setup(8'h14, 8'hfe);
		tx_frame(8'h40, 8'ha5, {2'b11, 8'ha5, 1'b0}, 10);
		wb_xfer(1'b0, OFF_CTRL, 8'h00);
		chk(q === 32'h14, "overflow flag set in baud mode");
	endtask

	task automatic m1_rx_aux();
		int n;
		baud_setup(8'h34, 8'hfe);
		wb_xfer(1'b1, OFF_SCTRL, 8'h50);
		serial_peer_inst.send_bits({2'b11, 8'h96, 1'b0}, 10);
		n = 0;
		do begin
			wb_xfer(1'b0, OFF_SCTRL, 8'h00);
			n++;
		end while (q[SC_RI] !== 1'b1 && n < 100);
		chk(q === 32'h55, "rx done and stop bit");
		wb_xfer(1'b0, OFF_SERIAL_BUFFER, 8'h00);
		chk(q === 32'h96, "received byte");
		wb_xfer(1'b1, OFF_SCTRL, 8'h00);
	endtask

	task automatic ext_trigger();
		baud_setup(8'h3c, 8'hfe);
		pulse_trig();
		wb_xfer(1'b0, OFF_CTRL, 8'h00);
		chk(q === 32'h7c, "ext flag only");
	endtask

	// timer stopped, so the captured and reloaded values are exact
	task automatic ext_capture_reload();
		wb_xfer(1'b1, OFF_CTRL, 8'h09);
		wb_xfer(1'b1, OFF_CNT_LO, 8'h34);
		wb_xfer(1'b1, OFF_CNT_HI, 8'h12);
		pulse_trig();
		wb_xfer(1'b0, OFF_RLD_LO, 8'h00);
		chk(q === 32'h34, "capture low");
		wb_xfer(1'b0, OFF_RLD_HI, 8'h00);
		chk(q === 32'h12, "capture high");
		wb_xfer(1'b0, OFF_CTRL, 8'h00);
		chk(q === 32'h49, "capture ext flag");
		wb_xfer(1'b1, OFF_CTRL, 8'h08);
		wb_xfer(1'b1, OFF_RLD_LO, 8'h78);
		wb_xfer(1'b1, OFF_RLD_HI, 8'h56);
		pulse_trig();
		wb_xfer(1'b0, OFF_CNT_LO, 8'h00);
		chk(q === 32'h78, "trigger reload low");
		wb_xfer(1'b0, OFF_CNT_HI, 8'h00);
		chk(q === 32'h56, "trigger reload high");
	endtask

	// three falls on the clock pin give a count of three
	task automatic counter_pin();
		wb_xfer(1'b1, OFF_CTRL, 8'h00);
		wb_xfer(1'b1, OFF_CNT_LO, 8'h00);
		wb_xfer(1'b1, OFF_CNT_HI, 8'h00);
		wb_xfer(1'b1, OFF_CTRL, 8'h06);
		repeat (3) begin
			@(posedge clk_i) clk_pin <= 1'b0;
			@(posedge clk_i) clk_pin <= 1'b1;
		end
		wb_xfer(1'b1, OFF_CTRL, 8'h00);
		wb_xfer(1'b0, OFF_CNT_LO, 8'h00);
		chk(q === 32'h03, "pin count low");
		wb_xfer(1'b0, OFF_CNT_HI, 8'h00);
		chk(q === 32'h00, "pin count high");
	endtask

	// other timer pulses every 2 clocks, every 2nd one a tick;
	// the auxiliary timer runs at half that rate so a wrong source shows
	task automatic m1_tx_other();
		baud_setup(8'h24, 8'hfc);
		@(posedge clk_i) gen_on <= 1'b1;
		tx_frame(8'h40, 8'h3c, {2'b11, 8'h3c, 1'b0}, 10);
		@(posedge clk_i) gen_on <= 1'b0;
	endtask

	task automatic m2_tx();
		wb_xfer(1'b1, OFF_CTRL, 8'h00);
		tx_frame(8'h88, 8'h5a, {2'b11, 8'h5a, 1'b0}, 11);
		baud_setup(8'h14, 8'hfe);
		tx_frame(8'hc0, 8'h00, {2'b10, 8'h00, 1'b0}, 11);
	endtask

	task automatic m0_tx();
		realtime t0;
		logic [7:0] got;
		wb_xfer(1'b1, OFF_SCTRL, 8'h00);
		fork
			wb_xfer(1'b1, OFF_SERIAL_BUFFER, 8'hc5);
			for (int i = 0; i < 8; i++) begin
				@(posedge txd_o);
				got[i] = rxd_o;
				chk(rxd_oe_o === 1'b1, "mode 0 drive");
				if (i > 0) chk($realtime - t0 == 60.0, "mode 0 rate");
				t0 = $realtime;
			end
		join
		chk(got === 8'hc5, "mode 0 data");
		repeat (12) @(posedge clk_i);
		wb_xfer(1'b0, OFF_SCTRL, 8'h00);
		chk(q[SC_TI] === 1'b1, "mode 0 tx done");
	endtask

	task automatic m0_rx();
		fork
			serial_peer_inst.feed_m0(8'h3a);
			wb_xfer(1'b1, OFF_SCTRL, 8'h10);
		join
		wb_xfer(1'b0, OFF_SCTRL, 8'h00);
		chk(q === 32'h11, "mode 0 rx done");
		wb_xfer(1'b0, OFF_SERIAL_BUFFER, 8'h00);
		chk(q === 32'h3a, "mode 0 rx data");
		wb_xfer(1'b1, OFF_SCTRL, 8'h00);
	endtask

	// ----------------------------------------------------------------
	// verdict, watchdog and main sequence
	// ----------------------------------------------------------------
	task automatic give_verdict();
		$display("errors %0d of %0d checks", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		#(5 * 60000);
		error_cnt++;
		$display("mismatch at %0t: watchdog expired", $time);
		give_verdict();
	end

	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		reset_values();
		m1_tx_aux();
		m1_rx_aux();
		ext_trigger();
		ext_capture_reload();
		counter_pin();
		m1_tx_other();
		m2_tx();
		m0_tx();
		m0_rx();
		give_verdict();
	end
endmodule

// File: aux_timer_pkg.sv
// constants for the auxiliary timer baud generator and serial port
// assumes a 32-bit classic wishbone bus with byte data in the low lane
package aux_timer_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [4:0] OFF_CTRL   = 5'h00;
	localparam logic [4:0] OFF_CNT_LO = 5'h04;
	localparam logic [4:0] OFF_CNT_HI = 5'h08;
	localparam logic [4:0] OFF_RLD_LO = 5'h0c;
	localparam logic [4:0] OFF_RLD_HI = 5'h10;
	localparam logic [4:0] OFF_SCTRL  = 5'h14;
	localparam logic [4:0] OFF_SERIAL_BUFFER   = 5'h18;
	localparam logic [4:0] OFF_CFG    = 5'h1c;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int TC_OVF   = 7;
	localparam int TC_EXT   = 6;
	localparam int TC_RCLK  = 5;
	localparam int TC_TX_CLOCK_SELECT  = 4;
	localparam int TC_EXEN  = 3;
	localparam int TC_RUN   = 2;
	localparam int TC_CSEL  = 1;
	localparam int TC_CAPRL = 0;
	localparam int SC_SM2   = 5;
	localparam int SC_REN   = 4;
	localparam int SC_TB8   = 3;
	localparam int SC_RB8   = 2;
	localparam int SC_TI    = 1;
	localparam int SC_RI    = 0;
	localparam int CFG_SMOD = 0;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [7:0]  BYTE_RST   = 8'h00;
	localparam logic [15:0] CNT_RST    = 16'h0000;
	localparam logic [15:0] CNT_MAX    = 16'hffff;
	localparam logic [3:0]  MACH_FIRST = 4'h0;
	localparam logic [3:0]  MACH_MID   = 4'h6;
	localparam logic [3:0]  MACH_LAST  = 4'hb;
	localparam logic [3:0]  OVS_MID    = 4'h7;
	localparam logic [3:0]  OVS_LAST   = 4'hf;
	localparam logic [3:0]  M0_LAST    = 4'h7;
	localparam logic [3:0]  RX_LAST    = 4'h9;
	localparam logic [3:0]  LEFT_M1    = 4'h9;
	localparam logic [3:0]  LEFT_M23   = 4'ha;

	typedef enum logic [1:0] {
		MODE_SHIFT = 2'b00,
		MODE_8BIT  = 2'b01,
		MODE_9FIX  = 2'b10,
		MODE_9VAR  = 2'b11
	} serial_mode_e;

endpackage

// File: serial_peer.sv
// remote serial device on the receive and transmit lines
// assumes the bench sets BIT_CLKS to the bit time in clock cycles
`timescale 1ns/1ps
module serial_peer #(
	parameter int BIT_CLKS = 64
) (
	input  wire logic clk_i,
	input  wire logic line_i,
	output logic      line_o
);
	// line released high between frames, as a pulled-up pin rests
	initial line_o = 1'b1;

	// ----------------------------------------------------------------
	// frame sender, lsb first, start and stop included in bits
	// ----------------------------------------------------------------
	task automatic send_bits(input logic [10:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i) line_o <= bits[i];
			repeat (BIT_CLKS - 1) @(posedge clk_i);
		end
		@(posedge clk_i) line_o <= 1'b1;
	endtask

	// ----------------------------------------------------------------
	// frame receiver, samples each bit at its middle
	// ----------------------------------------------------------------
	// ----------------------------------------------------------------
	// mode 0 partner: one bit per shift clock, set while the clock is low
	// ----------------------------------------------------------------
	task automatic feed_m0(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			@(negedge line_i) line_o <= d[i];
		end
		@(posedge line_i) line_o <= 1'b1;
	endtask

	task automatic recv_bits(output logic [10:0] bits, input int n);
		bits = 11'h7ff;
		@(negedge line_i);
		repeat (BIT_CLKS / 2) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			bits[i] = line_i;
			repeat (BIT_CLKS) @(posedge clk_i);
		end
	endtask
endmodule
